// ### core/swrt_regs.vh
// Constants of the supervisor watchdog: timebase rates, periods and tick counts.
// Assumes a 50 MHz system clock and inclusion by bare name.
`ifndef SWRT_REGS_VH
`define SWRT_REGS_VH

// System clock rate in Hz.
`define SWRT_SYS_CLK_HZ 50000000
// Internal oscillator nominal rate in Hz.
`define SWRT_OSC_HZ 10240
// System clocks per internal oscillator period.
`define SWRT_OSC_DIV (`SWRT_SYS_CLK_HZ / `SWRT_OSC_HZ)

// Internal oscillator periods in milliseconds.
`define SWRT_NORM_SHORT_MS 100
`define SWRT_NORM_LONG_MS 1600
`define SWRT_POST_RST_MS 1600
`define SWRT_RST_ACT_MS 200
// Least figures that the tick counts must meet, in milliseconds.
`define SWRT_RST_MIN_MS 140
`define SWRT_LONG_MIN_MS 1000
`define SWRT_NORM_MIN_MS 70
// Typical spacing of repeated reset pulses, in milliseconds.
`define SWRT_REPEAT_TYP_MS 1600

// Internal oscillator tick counts derived from the periods.
`define SWRT_INT_NORM_SHORT (`SWRT_NORM_SHORT_MS * `SWRT_OSC_HZ / 1000)
`define SWRT_INT_NORM_LONG (`SWRT_NORM_LONG_MS * `SWRT_OSC_HZ / 1000)
`define SWRT_INT_POST_RST (`SWRT_POST_RST_MS * `SWRT_OSC_HZ / 1000)
`define SWRT_INT_RST_ACT (`SWRT_RST_ACT_MS * `SWRT_OSC_HZ / 1000)

// External timebase clock counts.
`define SWRT_EXT_NORM 1024
`define SWRT_EXT_POST_RST 4096
`define SWRT_EXT_RST_ACT 2048

// Width of the period counter.
`define SWRT_CNT_W 15

// Controller state codes.
`define SWRT_ST_IDLE 2'h0
`define SWRT_ST_RUN 2'h1
`define SWRT_ST_RST 2'h2

`endif

// ### core/swrt_timebase.v
// Timebase tick generator of the supervisor watchdog.
// Assumes the external timebase level is synchronous to sys_clk_i.
`timescale 1ns/1ps
`include "swrt_regs.vh"

module swrt_timebase #(
	parameter OSC_DIV = `SWRT_OSC_DIV
) (
	input wire sys_clk_i,
	input wire resetn_i,
	input wire enable_i,
	input wire use_ext_i,
	input wire ext_clk_i,
	output wire tick_o
);

	reg [15:0] div_ff;
	reg [15:0] nxt_div;
	reg ext_prev_ff;
	reg ext_seen_ff;
	reg tick_ff;
	reg nxt_tick;
	wire ext_rise;
	wire [15:0] div_last;
	wire [31:0] div_span;

	assign div_span = OSC_DIV - 1;
	assign div_last = div_span[15:0];
	assign ext_rise = ext_seen_ff & ext_clk_i & ~ext_prev_ff;
	assign tick_o = tick_ff;

	// The divider stands in for the internal oscillator; the external level is edge counted.
	always @*
	begin
		nxt_div = div_ff;
		nxt_tick = 1'b0;
		if (!enable_i)
		begin
			nxt_div = 16'h0000;
		end
		else if (use_ext_i)
		begin
			nxt_div = 16'h0000;
			nxt_tick = ext_rise;
		end
		else if (div_ff == div_last)
		begin
			nxt_div = 16'h0000;
			nxt_tick = 1'b1;
		end
		else
		begin
			nxt_div = div_ff + 16'h0001;
		end
	end

	always @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			div_ff <= 16'h0000;
			tick_ff <= 1'b0;
			ext_prev_ff <= 1'b0;
			ext_seen_ff <= 1'b0;
		end
		else
		begin
			div_ff <= nxt_div;
			tick_ff <= nxt_tick;
			ext_prev_ff <= ext_clk_i;
			ext_seen_ff <= 1'b1;
		end
	end

endmodule

// ### core/swrt_watchdog.v
// Watchdog timer of a processor supervisor: kick monitor, reset pulse and fault flag.
// Assumes all inputs are synchronous to sys_clk_i and the supply comparators sit outside.
`timescale 1ns/1ps
`include "swrt_regs.vh"

module swrt_watchdog #(
	parameter HAS_SELECT = 1,
	parameter OSC_DIV = `SWRT_OSC_DIV,
	parameter INT_NORM_SHORT = `SWRT_INT_NORM_SHORT,
	parameter INT_NORM_LONG = `SWRT_INT_NORM_LONG,
	parameter INT_POST_RST = `SWRT_INT_POST_RST,
	parameter INT_RST_ACT = `SWRT_INT_RST_ACT,
	parameter EXT_NORM = `SWRT_EXT_NORM,
	parameter EXT_POST_RST = `SWRT_EXT_POST_RST,
	parameter EXT_RST_ACT = `SWRT_EXT_RST_ACT
) (
	input wire sys_clk_i,
	input wire resetn_i,
	input wire watchdog_kick_in_i,
	input wire kick_float_i,
	input wire timebase_select_i,
	input wire timebase_in_i,
	input wire supply_ok_i,
	input wire battery_backup_i,
	output wire cpu_reset_n_o,
	output wire watchdog_fault_n_o,
	output wire long_period_o,
	output wire wd_running_o,
	output wire wd_timeout_o
);

	localparam CW = `SWRT_CNT_W;
	localparam [CW-1:0] CNT_ONE = {{(CW-1){1'b0}}, 1'b1};
	localparam ST_IDLE = `SWRT_ST_IDLE;
	localparam ST_RUN = `SWRT_ST_RUN;
	localparam ST_RST = `SWRT_ST_RST;

	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [CW-1:0] cnt_ff;
	reg [CW-1:0] nxt_cnt;
	reg long_ff;
	reg nxt_long;
	reg rst_n_ff;
	reg nxt_rst_n;
	reg fault_n_ff;
	reg nxt_fault_n;
	reg timeout_ff;
	reg nxt_timeout;
	reg kick_prev_ff;
	reg kick_seen_ff;
	reg use_ext_ff;
	reg tb_level_ff;

	wire tick;
	wire supply_bad;
	wire enabled;
	wire kick_edge;
	wire [CW-1:0] wd_last;
	wire [CW-1:0] rst_last;
	wire at_wd_last;
	wire at_rst_last;

	// Last tick index of the watchdog period for the present mode.
	function [CW-1:0] wd_limit;
		input post;
		input ext;
		input tb_hi;
		input sel;
		reg [31:0] ticks;
		begin
			ticks = INT_NORM_LONG;
			if (!sel)
			begin
				ticks = INT_NORM_LONG;
			end
			else if (ext)
			begin
				ticks = post ? EXT_POST_RST : EXT_NORM;
			end
			else if (post)
			begin
				ticks = INT_POST_RST;
			end
			else
			begin
				ticks = tb_hi ? INT_NORM_LONG : INT_NORM_SHORT;
			end
			wd_limit = ticks[CW-1:0] - CNT_ONE;
		end
	endfunction

	// Last tick index of the reset pulse for the present mode.
	function [CW-1:0] rst_limit;
		input ext;
		input sel;
		reg [31:0] ticks;
		begin
			ticks = INT_RST_ACT;
			if (sel && ext)
			begin
				ticks = EXT_RST_ACT;
			end
			else
			begin
				ticks = INT_RST_ACT;
			end
			rst_limit = ticks[CW-1:0] - CNT_ONE;
		end
	endfunction

	assign supply_bad = ~supply_ok_i | battery_backup_i;
	assign enabled = ~supply_bad & ~kick_float_i;
	assign kick_edge = kick_seen_ff & ~battery_backup_i & ~kick_float_i
		& (watchdog_kick_in_i != kick_prev_ff);
	assign wd_last = wd_limit(long_ff, use_ext_ff, tb_level_ff, HAS_SELECT != 0);
	assign rst_last = rst_limit(use_ext_ff, HAS_SELECT != 0);
	assign at_wd_last = (cnt_ff == wd_last);
	assign at_rst_last = (cnt_ff == rst_last);

	swrt_timebase #(
		.OSC_DIV(OSC_DIV)
	) u_timebase (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.enable_i(~supply_bad),
		.use_ext_i(use_ext_ff),
		.ext_clk_i(timebase_in_i),
		.tick_o(tick)
	);

	// Timebase pin sampling; held while in back-up so the pins are ignored.
	always @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			use_ext_ff <= 1'b0;
			tb_level_ff <= 1'b1;
		end
		else if (!battery_backup_i)
		begin
			use_ext_ff <= (HAS_SELECT != 0) & ~timebase_select_i;
			tb_level_ff <= timebase_in_i;
		end
	end

	// Kick edge detector history.
	always @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			kick_prev_ff <= 1'b0;
			kick_seen_ff <= 1'b0;
		end
		else
		begin
			kick_prev_ff <= watchdog_kick_in_i;
			kick_seen_ff <= 1'b1;
		end
	end

	// Controller: idle, timing a watchdog period, or driving the reset pulse.
	always @*
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_long = long_ff;
		nxt_rst_n = rst_n_ff;
		nxt_timeout = 1'b0;
		case (state_ff)
		ST_IDLE:
		begin
			nxt_rst_n = 1'b1;
			nxt_cnt = {CW{1'b0}};
			nxt_long = 1'b1;
			if (enabled)
			begin
				nxt_state = ST_RUN;
			end
		end
		ST_RUN:
		begin
			nxt_rst_n = 1'b1;
			if (!enabled)
			begin
				nxt_state = ST_IDLE;
				nxt_cnt = {CW{1'b0}};
				nxt_long = 1'b1;
			end
			else if (kick_edge)
			begin
				nxt_cnt = {CW{1'b0}};
				nxt_long = 1'b0;
			end
			else if (tick)
			begin
				if (at_wd_last)
				begin
					nxt_state = ST_RST;
					nxt_cnt = {CW{1'b0}};
					nxt_rst_n = 1'b0;
					nxt_timeout = 1'b1;
				end
				else
				begin
					nxt_cnt = cnt_ff + CNT_ONE;
				end
			end
		end
		ST_RST:
		begin
			nxt_rst_n = 1'b0;
			if (supply_bad)
			begin
				nxt_state = ST_IDLE;
				nxt_cnt = {CW{1'b0}};
				nxt_rst_n = 1'b1;
				nxt_long = 1'b1;
			end
			else if (tick)
			begin
				if (at_rst_last)
				begin
					nxt_state = ST_RUN;
					nxt_cnt = {CW{1'b0}};
					nxt_rst_n = 1'b1;
					nxt_long = 1'b1;
				end
				else
				begin
					nxt_cnt = cnt_ff + CNT_ONE;
				end
			end
		end
		default:
		begin
			nxt_state = ST_IDLE;
			nxt_cnt = {CW{1'b0}};
			nxt_rst_n = 1'b1;
			nxt_long = 1'b1;
		end
		endcase
	end

	// Fault flag: low on timeout, high on the next kick edge or on supply loss.
	always @*
	begin
		nxt_fault_n = fault_n_ff;
		if (supply_bad)
		begin
			nxt_fault_n = 1'b1;
		end
		else if (kick_edge)
		begin
			nxt_fault_n = 1'b1;
		end
		else if (nxt_timeout)
		begin
			nxt_fault_n = 1'b0;
		end
	end

	always @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_ff <= ST_IDLE;
			cnt_ff <= {CW{1'b0}};
			long_ff <= 1'b1;
			rst_n_ff <= 1'b1;
			fault_n_ff <= 1'b1;
			timeout_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			long_ff <= nxt_long;
			rst_n_ff <= nxt_rst_n;
			fault_n_ff <= nxt_fault_n;
			timeout_ff <= nxt_timeout;
		end
	end

	assign cpu_reset_n_o = rst_n_ff;
	assign watchdog_fault_n_o = fault_n_ff;
	assign long_period_o = long_ff;
	assign wd_running_o = (state_ff == ST_RUN);
	assign wd_timeout_o = timeout_ff;

endmodule

// ### sim/swrt_watchdog_sva.sv
// Port checker of the supervisor watchdog, bound into swrt_watchdog.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ps
module swrt_watchdog_sva #(
	parameter OSC_DIV = 4,
	parameter INT_RST_ACT = 8
) (
	input wire sys_clk_i,
	input wire resetn_i,
	input wire watchdog_kick_in_i,
	input wire kick_float_i,
	input wire timebase_select_i,
	input wire timebase_in_i,
	input wire supply_ok_i,
	input wire battery_backup_i,
	input wire cpu_reset_n_o,
	input wire watchdog_fault_n_o,
	input wire long_period_o,
	input wire wd_running_o,
	input wire wd_timeout_o
);
	reg [15:0] low_cnt_ff;
	wire supply_bad = !supply_ok_i || battery_backup_i;
	wire kick_ok = !kick_float_i && !battery_backup_i;
	default clocking dc @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	// Counts the cycles that processor reset has been low.
	always @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			low_cnt_ff <= 16'h0000;
		else
			low_cnt_ff <= cpu_reset_n_o ? 16'h0000 : low_cnt_ff + 16'h0001;
	end
	timeout_fault_a: assert property ($fell(cpu_reset_n_o) |-> wd_timeout_o && !watchdog_fault_n_o)
		else $error("reset fell without timeout and fault");
	timeout_pulse_a: assert property (wd_timeout_o |=> !wd_timeout_o)
		else $error("timeout pulse too long");
	reset_width_a: assert property ($rose(cpu_reset_n_o) && timebase_select_i && supply_ok_i
		&& !battery_backup_i
		|-> low_cnt_ff >= INT_RST_ACT * OSC_DIV - 1 && low_cnt_ff <= INT_RST_ACT * OSC_DIV + 1)
		else $error("reset pulse width wrong");
	long_after_a: assert property ($rose(cpu_reset_n_o) |-> long_period_o)
		else $error("no long period after reset");
	restart_run_a: assert property ($rose(cpu_reset_n_o) && !supply_bad && !kick_float_i
		|-> wd_running_o)
		else $error("timing not restarted after reset");
	short_after_a: assert property ($changed(watchdog_kick_in_i) && kick_ok && !supply_bad
		&& wd_running_o && cpu_reset_n_o |=> !long_period_o)
		else $error("long period kept after kick");
	fault_kick_a: assert property ($changed(watchdog_kick_in_i) && kick_ok |=> watchdog_fault_n_o)
		else $error("fault not cleared by kick");
	fault_supply_a: assert property (supply_bad |=> watchdog_fault_n_o)
		else $error("fault low with bad supply");
	disable_bad_a: assert property (supply_bad |=> cpu_reset_n_o && !wd_running_o)
		else $error("timer active with bad supply");
	float_idle_a: assert property (kick_float_i && cpu_reset_n_o |=> !wd_running_o)
		else $error("timer active with floating kick");
endmodule
bind swrt_watchdog swrt_watchdog_sva #(.OSC_DIV(OSC_DIV), .INT_RST_ACT(INT_RST_ACT)) chk_u (
	.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .watchdog_kick_in_i(watchdog_kick_in_i),
	.kick_float_i(kick_float_i), .timebase_select_i(timebase_select_i),
	.timebase_in_i(timebase_in_i), .supply_ok_i(supply_ok_i),
	.battery_backup_i(battery_backup_i), .cpu_reset_n_o(cpu_reset_n_o),
	.watchdog_fault_n_o(watchdog_fault_n_o), .long_period_o(long_period_o),
	.wd_running_o(wd_running_o), .wd_timeout_o(wd_timeout_o)
);

// ### sim/swrt_host_kick.sv
// Host processor model that toggles the kick line.
// Assumes the bench sets the gap between kicks and the enable.
`timescale 1ns/1ps
module swrt_host_kick (
	input wire sys_clk_i,
	input wire enable_i,
	input wire [7:0] gap_i,
	output reg kick_o
);
	reg [7:0] wait_ff = 8'h00;
	initial kick_o = 1'b0;
	// Toggles once every gap plus one cycles while enabled.
	always @(posedge sys_clk_i)
	begin
		if (enable_i && wait_ff == 8'h00)
		begin
			kick_o <= #1 ~kick_o;
			wait_ff <= gap_i;
		end
		else if (wait_ff != 8'h00)
			wait_ff <= wait_ff - 8'h01;
	end
endmodule

// ### sim/tb.sv
// Self-checking bench of the supervisor watchdog with a host kick model.
// Assumes the core files are compiled first.
`timescale 1ns/1ps
module tb;
	reg sys_clk_i = 0;
	reg resetn_i = 0;
	reg kick_float_i = 0;
	reg timebase_select_i = 1;
	reg timebase_in_i = 1;
	reg supply_ok_i = 1;
	reg battery_backup_i = 0;
	reg kick_en = 0;
	reg ext_run = 0;
	reg [7:0] gap = 8'h04;
	wire watchdog_kick_in_i;
	wire cpu_reset_n_o;
	wire watchdog_fault_n_o;
	wire long_period_o;
	wire wd_running_o;
	wire wd_timeout_o;
	integer n_fail = 0;
	integer checks_done = 0;
	integer n_rst = 0;
	integer t;
	integer r;
	swrt_watchdog #(.OSC_DIV(4), .INT_NORM_SHORT(4), .INT_NORM_LONG(32), .INT_POST_RST(32),
		.INT_RST_ACT(8)) dut_u (
		.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .watchdog_kick_in_i(watchdog_kick_in_i),
		.kick_float_i(kick_float_i), .timebase_select_i(timebase_select_i),
		.timebase_in_i(timebase_in_i), .supply_ok_i(supply_ok_i),
		.battery_backup_i(battery_backup_i), .cpu_reset_n_o(cpu_reset_n_o),
		.watchdog_fault_n_o(watchdog_fault_n_o), .long_period_o(long_period_o),
		.wd_running_o(wd_running_o), .wd_timeout_o(wd_timeout_o)
	);
	swrt_host_kick host_u (.sys_clk_i(sys_clk_i), .enable_i(kick_en), .gap_i(gap),
		.kick_o(watchdog_kick_in_i));
	initial forever #10 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) if (ext_run) timebase_in_i <= #1 ~timebase_in_i;
	always @(negedge cpu_reset_n_o) n_rst = n_rst + 1;
	task cyc(input integer n);
		begin
			repeat (n) @(posedge sys_clk_i);
			#1;
		end
	endtask
	task chk(input [31:0] got, input [31:0] lo, input [31:0] hi);
		begin
			checks_done = checks_done + 1;
			if (^got === 1'bx || got < lo || got > hi)
			begin
				n_fail = n_fail + 1;
				$display("mismatch at %0t: got %h expected %h to %h", $time, got, lo, hi);
			end
		end
	endtask
	// Waits for a timeout of n ticks of d cycles, then for the m-tick reset pulse.
	task measure(input integer n, input integer d, input integer m);
		begin
			t = 0;
			while (cpu_reset_n_o === 1'b1 && t < 20000)
			begin
				cyc(1);
				t = t + 1;
			end
			chk(t, (n - 1) * d, n * d + 6);
			chk(wd_timeout_o, 1, 1);
			chk(watchdog_fault_n_o, 0, 0);
			t = 0;
			while (cpu_reset_n_o === 1'b0 && t < 20000)
			begin
				cyc(1);
				t = t + 1;
			end
			chk(t, (m - 1) * d, m * d + 2);
			chk(long_period_o, 1, 1);
		end
	endtask
	task quiet(input integer n);
		integer k;
		begin
			k = n_rst;
			cyc(n);
			chk(n_rst - k, 0, 0);
		end
	endtask
	task kick_once;
		begin
			kick_en = 1;
			cyc(1);
			kick_en = 0;
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d failures %0d", checks_done, n_fail);
			if (n_fail == 0 && checks_done > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	initial
	begin
		#1400000;
		n_fail = n_fail + 1;
		finish_test;
	end
	initial
	begin
		r = $urandom(62);
		cyc(10);
		resetn_i = 1;
		measure(32, 4, 8);
		measure(32, 4, 8);
		repeat (3)
		begin
			gap = 8'($urandom_range(8, 1));
			kick_en = 1;
			quiet(200);
		end
		chk(watchdog_fault_n_o, 1, 1);
		chk(long_period_o, 0, 0);
		kick_en = 0;
		cyc(10);
		kick_once;
		measure(32, 4, 8);
		timebase_in_i = 0;
		kick_once;
		measure(4, 4, 8);
		resetn_i = 0;
		timebase_select_i = 0;
		ext_run = 1;
		cyc(2);
		resetn_i = 1;
		measure(4096, 2, 2048);
		kick_once;
		measure(1024, 2, 2048);
		kick_float_i = 1;
		cyc(2);
		chk(wd_running_o, 0, 0);
		quiet(100);
		kick_float_i = 0;
		supply_ok_i = 0;
		cyc(2);
		chk(watchdog_fault_n_o, 1, 1);
		quiet(100);
		supply_ok_i = 1;
		measure(4096, 2, 2048);
		battery_backup_i = 1;
		kick_en = 1;
		cyc(2);
		chk(watchdog_fault_n_o, 1, 1);
		quiet(100);
		finish_test;
	end
endmodule
